//--- rtl/dvmseq_top.sv
// digitizing sequencer of a five-digit voltmeter: timing, pulse counter, catchers, ranging, readout
// assumes oscillator pulses and panel inputs are one-cycle or level signals synchronous to clk_sys_i
// Notes on behaviour
// [R1] six periods zero, a to e, one-hot
// [R2] measure storage pulse returns sequencer to zero
// [R3] four-bit counter weighted 8421, counts to twelve
// [R4] timing pulse clears counter each period
// [R5] count nine stops oscillator outside period a
// [R6] conditional eleven halts counter in period a
// [R7] twelve in a: overrange lamp on, up-range only in measure cycles
// [R8] oscillator inhibited throughout f phase
// [R9] no new cycle before present one completes
// [R10] front-panel range switches beat auto ranging
// [R11] range register 00,01,10,11 for 1..1000
// [R12] one of four range lines per range
// [R13] w and x set asks up-range in a
// [R14] all bits zero asks down-range in a
// [R15] settle 10 ms plain, 230 ms filtered
// [R16] anode on in second half, matching period
// [R17] bcd to active-low one-of-ten digit select
// [R18] overrange digit lit when a count reaches ten
// [R19] master tick, toggle stage, jk f phase, h pulse
// [R20] measure only if requested before a, else store
// [R21] one step per h pulse, zero after reset
`timescale 1ns/100ps
`include "dvmseq_defs.svh"

module dvmseq_top #(
  parameter int MTICK_CYC     = `DVMSEQ_MTICK_CYC,
  parameter int SETTLE_NF_CYC = `DVMSEQ_SETTLE_NF_CYC,
  parameter int SETTLE_F_CYC  = `DVMSEQ_SETTLE_F_CYC
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    srst_i,
  input  wire logic                    osc_pulse_i,
  input  wire logic                    measure_req_i,
  input  wire logic                    auto_range_i,
  input  wire logic                    manual_sel_i,
  input  wire logic [1:0]              manual_range_i,
  input  wire logic                    filter_sel_i,
  output logic                         h_pulse_o,
  output logic                         f_phase_o,
  output logic [4:0]                   period_o,
  output logic                         meas_store_o,
  output logic                         meas_start_o,
  output logic                         meas_cycle_o,
  output logic                         pulse_oscillator_run_o,
  output logic [3:0]                   count_o,
  output logic                         range_up_req_o,
  output logic                         range_decrease_req_o,
  output logic                         range_reg_hi_o,
  output logic                         range_reg_lo_o,
  output logic [3:0]                   range_line_o,
  output logic                         settle_busy_o,
  output logic                         over_lamp_o,
  output dvmseq_pkg::dvmseq_readout_t  readout_o
);
  import dvmseq_pkg::*;

  function automatic logic [3:0] line_of(input logic [1:0] code);
    line_of = 4'h1 << code;
  endfunction

  function automatic logic [9:0] digit_of(input logic [3:0] cnt);
    logic [3:0] d;
    d = (cnt >= `DVMSEQ_CNT_TEN) ? 4'(cnt - `DVMSEQ_CNT_TEN) : cnt;
    digit_of = ~(10'h001 << d);
  endfunction

  logic [23:0]     mtick_cnt_reg;
  logic            tog_reg;
  logic            f_reg;
  logic [4:0]      seq_reg;
  dvmseq_cyc_t     cyc_reg;
  logic            pend_reg;
  logic            start_reg;
  logic            store_reg;
  logic [3:0]      cnt_reg;
  logic [1:0]      range_reg;
  logic [1:0]      range_next;
  logic [23:0]     settle_reg;
  logic            up_reg;
  logic            decr_reg;
  logic            lamp_reg;
  dvmseq_readout_t ro_reg;
  logic            mtick;
  logic            f_rise;
  logic            h_tick;
  logic            in_a;
  logic            osc_run;
  logic            nine_stop;
  logic            halt11;
  logic            enter_a;
  logic            go_meas;
  logic            up_cond;
  logic            decr_cond;

  // master clock divider, toggle stage and jk f phase
  assign mtick  = (mtick_cnt_reg == 24'(MTICK_CYC - 1)); // [R19]
  assign f_rise = mtick & ~tog_reg & ~f_reg;
  assign h_tick = mtick & ~tog_reg & f_reg; // [R19]

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || mtick) begin
      mtick_cnt_reg <= 24'h000000;
    end else begin
      mtick_cnt_reg <= mtick_cnt_reg + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tog_reg <= 1'b0;
      f_reg   <= 1'b0;
    end else if (mtick) begin
      tog_reg <= ~tog_reg;
      if (!tog_reg) begin
        f_reg <= ~f_reg; // [R19]
      end
    end
  end

  // six period sequencer
  assign in_a    = seq_reg[`DVMSEQ_PER_A];
  assign enter_a = h_tick & (seq_reg == `DVMSEQ_SEQ_ZERO);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      seq_reg <= `DVMSEQ_SEQ_ZERO; // [R21]
    end else if (h_tick) begin
      if (seq_reg[`DVMSEQ_PER_E]) begin
        seq_reg <= `DVMSEQ_SEQ_ZERO; // [R2]
      end else if (seq_reg == `DVMSEQ_SEQ_ZERO) begin
        seq_reg <= `DVMSEQ_SEQ_A; // [R1]
      end else begin
        seq_reg <= {seq_reg[3:0], 1'b0}; // [R21]
      end
    end
  end

  // cycle control: requests held until an a entry with settling done
  assign go_meas = pend_reg & (settle_reg == 24'h000000);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
    end else if (measure_req_i) begin
      pend_reg <= 1'b1; // [R9]
    end else if (enter_a && go_meas) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cyc_reg   <= CYC_STORE;
      start_reg <= 1'b0;
      store_reg <= 1'b0;
    end else begin
      start_reg <= enter_a & go_meas;
      store_reg <= h_tick & seq_reg[`DVMSEQ_PER_E]; // [R2]
      if (enter_a) begin
        case (cyc_reg)
          CYC_STORE: cyc_reg <= go_meas ? CYC_MEAS : CYC_STORE; // [R20]
          CYC_MEAS:  cyc_reg <= go_meas ? CYC_MEAS : CYC_STORE; // [R20]
          default:   cyc_reg <= CYC_STORE;
        endcase
      end
    end
  end

  // oscillator gating and pulse counter with catchers
  assign nine_stop = ~in_a & (cnt_reg == `DVMSEQ_CNT_NINE); // [R5]
  assign halt11    = in_a & ~auto_range_i & (cnt_reg == `DVMSEQ_CNT_ELEVEN); // [R6]
  assign osc_run   = ~f_reg & (|seq_reg) & ~nine_stop & ~halt11 & (cnt_reg != `DVMSEQ_CNT_MAX); // [R8]

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || h_tick) begin
      cnt_reg <= `DVMSEQ_CNT_ZERO; // [R4]
    end else if (osc_pulse_i && osc_run) begin
      cnt_reg <= cnt_reg + 4'h1; // [R3]
    end
  end

  // ranging, manual first, auto judged at end of a counting half
  assign up_cond = auto_range_i & (cyc_reg == CYC_MEAS) & in_a & cnt_reg[3] & cnt_reg[2]; // [R13]
  assign decr_cond = auto_range_i & (cyc_reg == CYC_MEAS) & in_a & (cnt_reg == `DVMSEQ_CNT_ZERO); // [R14]

  always_comb begin
    range_next = range_reg;
    if (manual_sel_i) begin
      range_next = manual_range_i; // [R10]
    end else if (f_rise && up_cond && range_reg != `DVMSEQ_RANGE_TOP) begin
      range_next = range_reg + 2'h1; // [R7]
    end else if (f_rise && decr_cond && range_reg != `DVMSEQ_RANGE_RST) begin
      range_next = range_reg - 2'h1; // [R14]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      range_reg <= `DVMSEQ_RANGE_RST;
      up_reg    <= 1'b0;
      decr_reg  <= 1'b0;
    end else begin
      range_reg <= range_next; // [R11]
      up_reg    <= f_rise & up_cond; // [R13]
      decr_reg  <= f_rise & decr_cond; // [R14]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      settle_reg <= 24'h000000;
    end else if (range_next != range_reg) begin
      settle_reg <= filter_sel_i ? 24'(SETTLE_F_CYC) : 24'(SETTLE_NF_CYC); // [R15]
    end else if (settle_reg != 24'h000000) begin
      settle_reg <= settle_reg - 24'h000001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      lamp_reg <= 1'b0;
    end else if (in_a && cnt_reg == `DVMSEQ_CNT_MAX) begin
      lamp_reg <= 1'b1; // [R7]
    end else if (start_reg) begin
      lamp_reg <= 1'b0;
    end
  end

  // readout decoder and anode strobing
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ro_reg.digit_sel_n <= `DVMSEQ_DIGIT_OFF;
      ro_reg.anode_en    <= 5'h00;
      ro_reg.over_digit  <= 1'b0;
    end else begin
      ro_reg.digit_sel_n <= digit_of(cnt_reg); // [R17]
      ro_reg.anode_en    <= seq_reg & {5{f_reg}}; // [R16]
      ro_reg.over_digit  <= f_reg & in_a & (cnt_reg >= `DVMSEQ_CNT_TEN); // [R18]
    end
  end

  assign h_pulse_o              = h_tick;
  assign f_phase_o              = f_reg;
  assign period_o               = seq_reg;
  assign meas_store_o           = store_reg;
  assign meas_start_o           = start_reg;
  assign meas_cycle_o           = (cyc_reg == CYC_MEAS);
  assign pulse_oscillator_run_o = osc_run;
  assign count_o                = cnt_reg;
  assign range_up_req_o         = up_reg;
  assign range_decrease_req_o   = decr_reg;
  assign range_reg_hi_o         = range_reg[1]; // [R11]
  assign range_reg_lo_o         = range_reg[0];
  assign range_line_o           = line_of(range_reg); // [R12]
  assign settle_busy_o          = (settle_reg != 24'h000000);
  assign over_lamp_o            = lamp_reg;
  assign readout_o              = ro_reg;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_last_step;
    h_tick && seq_reg[`DVMSEQ_PER_E];
  endsequence
  sequence s_back_to_zero;
    (seq_reg == `DVMSEQ_SEQ_ZERO) && store_reg;
  endsequence

  property p_onehot;
    $onehot0(seq_reg);
  endproperty
  a_onehot: assert property (p_onehot) else $error("period code not one-hot"); // [R1]

  property p_store_reset;
    s_last_step |=> s_back_to_zero;
  endproperty
  a_store_reset: assert property (p_store_reset) else $error("storage pulse did not clear period"); // [R2]

  property p_count_cap;
    cnt_reg <= `DVMSEQ_CNT_MAX;
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("count above twelve"); // [R3]

  property p_clear;
    h_tick |=> (cnt_reg == `DVMSEQ_CNT_ZERO);
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared by timing pulse"); // [R4]

  property p_nine;
    (!in_a && cnt_reg == `DVMSEQ_CNT_NINE && !h_tick) |=> cnt_reg == `DVMSEQ_CNT_NINE;
  endproperty
  a_nine: assert property (p_nine) else $error("oscillator ran past nine"); // [R5]

  property p_fstop;
    f_reg && osc_pulse_i |=> $stable(cnt_reg) || cnt_reg == `DVMSEQ_CNT_ZERO;
  endproperty
  a_fstop: assert property (p_fstop) else $error("counted during f phase"); // [R8]

  property p_step;
    h_tick && in_a |=> seq_reg[1] && !in_a;
  endproperty
  a_step: assert property (p_step) else $error("sequencer did not step a to b"); // [R21]

  property p_anode;
    (ro_reg.anode_en != 5'h00) |-> $past(f_reg) && (ro_reg.anode_en == $past(seq_reg));
  endproperty
  a_anode: assert property (p_anode) else $error("anode outside second half"); // [R16]

  property p_digit;
    $past(srst_i) || $onehot(~ro_reg.digit_sel_n);
  endproperty
  a_digit: assert property (p_digit) else $error("digit select not one-of-ten"); // [R17]

  property p_range_line;
    $onehot(range_line_o) && range_line_o[range_reg];
  endproperty
  a_range_line: assert property (p_range_line) else $error("range line mismatch"); // [R12]

  property p_manual;
    manual_sel_i |=> range_reg == $past(manual_range_i);
  endproperty
  a_manual: assert property (p_manual) else $error("manual range not taken"); // [R10]

  property p_up;
    up_reg |-> $past(in_a) && $past(cnt_reg) == `DVMSEQ_CNT_MAX;
  endproperty
  a_up: assert property (p_up) else $error("up-range without twelve in a"); // [R13]

  sequence s_a_no_request;
    enter_a && !go_meas;
  endsequence
  sequence s_stays_store;
    (cyc_reg == CYC_STORE) && !start_reg;
  endsequence

  property p_store_again;
    s_a_no_request |=> s_stays_store;
  endproperty
  a_store_again: assert property (p_store_again) else $error("measure cycle without request"); // [R20]

  property p_down;
    decr_reg |-> $past(in_a) && $past(cnt_reg) == `DVMSEQ_CNT_ZERO;
  endproperty
  a_down: assert property (p_down) else $error("down-range without zero in a"); // [R14]

  property p_halt11;
    (in_a && !auto_range_i && cnt_reg == `DVMSEQ_CNT_ELEVEN && !h_tick) |=> cnt_reg == `DVMSEQ_CNT_ELEVEN;
  endproperty
  a_halt11: assert property (p_halt11) else $error("counter ran past eleven"); // [R6]

  property p_lamp;
    (in_a && cnt_reg == `DVMSEQ_CNT_MAX) |=> lamp_reg;
  endproperty
  a_lamp: assert property (p_lamp) else $error("overrange lamp not lit"); // [R7]

  property p_settle;
    $changed(range_reg) |-> settle_reg != 24'h000000;
  endproperty
  a_settle: assert property (p_settle) else $error("no settle after range change"); // [R15]
endmodule

//--- rtl/dvmseq_defs.svh
// constants for the voltmeter digitizing sequencer: offsets of fields, reset values, timing counts
// assumes inclusion by bare name from the top module
`ifndef DVMSEQ_DEFS_SVH
`define DVMSEQ_DEFS_SVH

`define DVMSEQ_CLK_HZ        20000000
`define DVMSEQ_PERIOD_US     3000
`define DVMSEQ_MTICK_CYC     (((`DVMSEQ_CLK_HZ / 1000000) * `DVMSEQ_PERIOD_US) / 4)
`define DVMSEQ_SETTLE_NF_MS  10
`define DVMSEQ_SETTLE_F_MS   230
`define DVMSEQ_SETTLE_NF_CYC ((`DVMSEQ_CLK_HZ / 1000) * `DVMSEQ_SETTLE_NF_MS)
`define DVMSEQ_SETTLE_F_CYC  ((`DVMSEQ_CLK_HZ / 1000) * `DVMSEQ_SETTLE_F_MS)

`define DVMSEQ_PER_A         0
`define DVMSEQ_PER_E         4
`define DVMSEQ_SEQ_ZERO      5'h00
`define DVMSEQ_SEQ_A         5'h01

`define DVMSEQ_CNT_NINE      4'h9
`define DVMSEQ_CNT_TEN       4'ha
`define DVMSEQ_CNT_ELEVEN    4'hb
`define DVMSEQ_CNT_MAX       4'hc
`define DVMSEQ_CNT_ZERO      4'h0

`define DVMSEQ_RANGE_RST     2'h0
`define DVMSEQ_RANGE_TOP     2'h3
`define DVMSEQ_DIGIT_OFF     10'h3ff

`endif

//--- rtl/dvmseq_pkg.sv
// types shared by the digitizing sequencer
// assumes the constants header sits beside it
package dvmseq_pkg;
  typedef enum logic [1:0] {
    CYC_STORE = 2'h0,
    CYC_MEAS  = 2'h1
  } dvmseq_cyc_t;

  typedef struct packed {
    logic [9:0] digit_sel_n;
    logic [4:0] anode_en;
    logic       over_digit;
  } dvmseq_readout_t;
endpackage

//--- sim/dvmseq_osc_model.sv
// behavioural pulse oscillator beside the digitizing sequencer
// assumes run and timing pulse come from the sequencer on the same clock
`timescale 1ns/100ps
module dvmseq_osc_model (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       run_i,
  input  wire logic       h_pulse_i,
  input  wire logic [4:0] target_i,
  output logic            osc_pulse_o
);
  logic [4:0] sent_reg;
  // one pulse every other cycle while enabled, up to target per period
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || h_pulse_i) begin
      sent_reg    <= 5'h00;
      osc_pulse_o <= 1'b0;
    end else if (run_i && !osc_pulse_o && sent_reg < target_i) begin
      sent_reg    <= sent_reg + 5'h01;
      osc_pulse_o <= 1'b1;
    end else begin
      osc_pulse_o <= 1'b0;
    end
  end
endmodule

//--- sim/testbench.sv
// self-checking bench for the digitizing sequencer
// assumes short timing parameters and the oscillator model beside it
`timescale 1ns/100ps
module testbench;
  import dvmseq_pkg::*;
  logic            clk_sys_i = 0, srst_i = 1, meas_req = 0, auto_rng = 0, man_sel = 0, filt = 0;
  logic [1:0]      man_rng = 2'h0;
  logic [4:0]      target = 5'h00;
  logic            osc, h_pulse, f_phase, store, start, meas_cyc, run, up_req, decr_req, r_hi, r_lo, busy, lamp;
  logic [4:0]      period;
  logic [3:0]      count, rline;
  dvmseq_readout_t rd;
  int              fail_count = 0, checked = 0, up_n = 0, decr_n = 0, store_n = 0, start_n = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (up_req === 1'b1) up_n++;
    if (decr_req === 1'b1) decr_n++;
    if (store === 1'b1) store_n++;
    if (start === 1'b1) start_n++;
  end

  dvmseq_top #(.MTICK_CYC(16), .SETTLE_NF_CYC(8), .SETTLE_F_CYC(20)) u_dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .osc_pulse_i(osc), .measure_req_i(meas_req),
    .auto_range_i(auto_rng), .manual_sel_i(man_sel), .manual_range_i(man_rng), .filter_sel_i(filt),
    .h_pulse_o(h_pulse), .f_phase_o(f_phase), .period_o(period), .meas_store_o(store),
    .meas_start_o(start), .meas_cycle_o(meas_cyc), .pulse_oscillator_run_o(run), .count_o(count),
    .range_up_req_o(up_req), .range_decrease_req_o(decr_req), .range_reg_hi_o(r_hi), .range_reg_lo_o(r_lo),
    .range_line_o(rline), .settle_busy_o(busy), .over_lamp_o(lamp), .readout_o(rd));
  dvmseq_osc_model u_osc (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .run_i(run), .h_pulse_i(h_pulse),
    .target_i(target), .osc_pulse_o(osc));

  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic waith();
    int n = 0;
    do begin @(negedge clk_sys_i); n++; end while (h_pulse !== 1'b1 && n < 200);
    check(n < 200, "timing pulse missing");
    cyc(1);
  endtask
  task automatic goper(input logic [4:0] p);
    int n = 0;
    do begin waith(); n++; end while (period !== p && n < 8);
    check(period === p, "period not reached");
  endtask
  task automatic frise();
    int n = 0;
    while (f_phase !== 1'b1 && n < 80) begin cyc(1); n++; end
    cyc(3);
  endtask
  task automatic wait_evt(ref int c);
    int c0 = c;
    int n = 0;
    while (c == c0 && n < 100) begin cyc(1); n++; end
    check(c != c0, "range step missing");
    cyc(2);
  endtask

  task automatic t_seq();
    int s0;
    check(period === 5'h00 && count === 4'h0 && rd.digit_sel_n === 10'h3ff && lamp === 1'b0, "reset");
    goper(5'h01);
    for (int i = 1; i < 5; i++) begin
      waith();
      check(period === (5'h01 << i), "period order");
    end
    s0 = store_n;
    waith();
    cyc(2);
    check(store_n == s0 + 1 && period === 5'h00, "store pulse");
  endtask
  task automatic t_count();
    target = 5'h05;
    goper(5'h04);
    frise();
    check(count === 4'h5 && rd.digit_sel_n === ~10'h020, "count five");
    check(rd.anode_en === 5'h04, "anode position");
    check(run === 1'b0, "oscillator on in f phase");
    waith();
    check(count === 4'h0, "count clear");
    check(run === 1'b1, "oscillator off while counting");
    target = 5'h0f;
    goper(5'h02);
    frise();
    check(count === 4'h9, "nine stop");
  endtask
  task automatic t_meas();
    int s0;
    goper(5'h02);
    s0 = start_n;
    meas_req = 1'b1;
    cyc(1);
    meas_req = 1'b0;
    goper(5'h10);
    check(start_n == s0, "early start");
    goper(5'h01);
    cyc(2);
    check(start_n == s0 + 1 && meas_cyc === 1'b1, "measure start");
  endtask
  task automatic t_range();
    meas_req = 1'b1;
    goper(5'h01);
    frise();
    check(count === 4'hb && rd.over_digit === 1'b1 && rd.digit_sel_n === ~10'h002, "eleven");
    auto_rng = 1'b1;
    goper(5'h01);
    wait_evt(up_n);
    check(count === 4'hc && lamp === 1'b1 && {r_hi, r_lo} === 2'h1, "up step");
    check(busy === 1'b1, "settle start");
    cyc(10);
    check(busy === 1'b0, "short settle");
    filt = 1'b1;
    goper(5'h01);
    wait_evt(up_n);
    cyc(12);
    check(busy === 1'b1 && {r_hi, r_lo} === 2'h2, "long settle");
    cyc(10);
    check(busy === 1'b0, "long settle end");
    target = 5'h00;
    goper(5'h01);
    wait_evt(decr_n);
    check({r_hi, r_lo} === 2'h1, "down step");
    man_sel = 1'b1;
    for (int r = 0; r < 4; r++) begin
      man_rng = r[1:0];
      cyc(3);
      check({r_hi, r_lo} === r[1:0] && rline === (4'h1 << r), "manual range");
    end
    man_sel = 1'b0;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(50 * 30000);
    fail_count++;
    results();
  end
  initial begin
    cyc(4);
    srst_i = 1'b0;
    t_seq();
    t_count();
    t_meas();
    t_range();
    results();
  end
endmodule
